// file: rtl/smie_pkg.sv
package smie_pkg;

    // ------------------------------------------------------------
    // Entry sequence timing
    // ------------------------------------------------------------
    // Cycles spent in the entry sequence before the mode is in force
    localparam logic [3:0] ENTRY_CYCLES = 4'h4;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    localparam logic [2:0] SYNC_RESET = 3'h7;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SMIE_RUN,
        SMIE_WAIT_BOUNDARY,
        SMIE_ENTRY,
        SMIE_MGMT
    } smie_state_t;

endpackage

// file: rtl/smie_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Three-stage synchroniser with falling edge detect
// ----------------------------------------------------------------
// The first stage is read only by the second; the edge is judged
// once stages two and three agree on the new level.
module smie_edge_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_n,
    output logic fall_pulse
);

    typedef struct packed {
        logic [2:0] sync;
        logic stable;
        logic fall;
    } smie_sync_st_t;

    smie_sync_st_t s_q;
    smie_sync_st_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.sync = {s_q.sync[1:0], pin_n};
        s_d.fall = 1'b0;
        if (s_q.sync[1] == s_q.sync[2]) begin
            s_d.stable = s_q.sync[2];
            if (s_q.stable && !s_q.sync[2]) begin
                s_d.fall = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{sync: smie_pkg::SYNC_RESET, stable: 1'b1, fall: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign fall_pulse = s_q.fall;

endmodule

`default_nettype wire

// file: rtl/smie_pending.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Pending request latch
// ----------------------------------------------------------------
// A new edge in the same cycle as the take keeps the latch set.
module smie_pending (
    input wire logic clk,
    input wire logic rst,
    input wire logic set_pulse,
    input wire logic take,
    output logic pending
);

    typedef struct packed {
        logic pend;
    } smie_pend_st_t;

    smie_pend_st_t p_q;
    smie_pend_st_t p_d;

    always_comb begin
        p_d = p_q;
        if (take) begin
            p_d.pend = 1'b0; // RL12
        end
        if (set_pulse) begin
            p_d.pend = 1'b1; // RL1 RL7
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            p_q <= '{pend: 1'b0};
        end else begin
            p_q <= p_d;
        end
    end

    assign pending = p_q.pend;

endmodule

`default_nettype wire

// file: rtl/smie_entry.sv
`timescale 1ns/10ps
`default_nettype none

// Function
// RL1: Latch request on falling edge of input.
// RL2: Management request outranks all other interrupts.
// RL3: Finish current instruction, then enter mode.
// RL4: Test at boundaries and string iterations.
// RL5: Defer entry while locked cycles run.
// RL6: No nested entry during management mode.
// RL7: Record new edge during management mode.
// RL8: Serve recorded request only after resume.
// RL9: Assert active indicator when entry starts.
// RL10: Indicator low from entry until resume.
// RL11: Indicator high during hold and reset.
// RL12: Clear pending when its entry begins.
// RL13: Drive bus lock during locked sequences.
// RL14: Requester signals by a falling edge.
module smie_entry (
    input wire logic clk,
    input wire logic rst,
    input wire logic mgmt_irq_req_n,
    input wire logic instr_boundary,
    input wire logic string_iter_boundary,
    input wire logic locked_seq,
    input wire logic hold_ack,
    input wire logic resume_from_mgmt_instr,
    input wire logic other_irq_req,
    output logic mgmt_mode_active_n,
    output logic lock_n,
    output logic mgmt_entry_start,
    output logic other_irq_take,
    output logic system_mgmt_state
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        smie_pkg::smie_state_t state;
        logic [3:0] cnt;
        logic act_n;
        logic lock_n;
        logic start;
        logic other_take;
        logic in_mgmt;
    } smie_st_t;

    smie_st_t r_q;
    smie_st_t r_d;

    // Request path
    logic fall_pulse;
    logic pending;
    logic take;

    // Boundary gate
    logic boundary;
    logic gate_open;

    // State decode
    logic is_run;
    logic is_wait;
    logic is_entry;
    logic is_mgmt;
    logic can_enter;

    // Entry counter and exit
    logic entry_last;
    logic [3:0] cnt_dec;
    logic resume_hit;
    logic other_ok;

    // Request enters through a three-flop synchroniser
    smie_edge_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pin_n(mgmt_irq_req_n),
        .fall_pulse(fall_pulse)
    );

    smie_pending u_pend (
        .clk(clk),
        .rst(rst),
        .set_pulse(fall_pulse),
        .take(take),
        .pending(pending)
    );

    // ------------------------------------------------------------
    // State decode
    // ------------------------------------------------------------
    assign is_run = (r_q.state == smie_pkg::SMIE_RUN);
    assign is_wait = (r_q.state == smie_pkg::SMIE_WAIT_BOUNDARY);
    assign is_entry = (r_q.state == smie_pkg::SMIE_ENTRY);
    assign is_mgmt = (r_q.state == smie_pkg::SMIE_MGMT);
    // Entry only from run or wait, so no nesting inside the mode
    assign can_enter = is_run || is_wait; // RL6 RL8

    // ------------------------------------------------------------
    // Take decision
    // ------------------------------------------------------------
    // Only whole instructions or single string iterations end here,
    // so nothing is ever aborted midway.
    assign boundary = instr_boundary || string_iter_boundary; // RL3 RL4
    // Locked sequences hold off the take
    assign gate_open = boundary && !locked_seq; // RL5
    // Wait may take as well: a one-cycle boundary is never lost
    assign take = pending && gate_open && can_enter;

    // ------------------------------------------------------------
    // Entry counter
    // ------------------------------------------------------------
    assign entry_last = (r_q.cnt == smie_pkg::CNT_ONE);
    assign cnt_dec = r_q.cnt - smie_pkg::CNT_ONE;

    // ------------------------------------------------------------
    // Exit and other sources
    // ------------------------------------------------------------
    assign resume_hit = is_mgmt && resume_from_mgmt_instr; // RL8
    // Pending management request masks other sources
    assign other_ok = is_run && !pending && other_irq_req
        && instr_boundary; // RL2

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_d = r_q;

        unique case (r_q.state)
            smie_pkg::SMIE_RUN: begin
                if (take) begin
                    r_d.state = smie_pkg::SMIE_ENTRY;
                end else if (pending) begin
                    r_d.state = smie_pkg::SMIE_WAIT_BOUNDARY; // RL2
                end
            end
            smie_pkg::SMIE_WAIT_BOUNDARY: begin
                if (take) begin
                    r_d.state = smie_pkg::SMIE_ENTRY; // RL3
                end
            end
            smie_pkg::SMIE_ENTRY: begin
                if (entry_last) begin
                    r_d.state = smie_pkg::SMIE_MGMT;
                end
            end
            smie_pkg::SMIE_MGMT: begin
                if (resume_hit) begin
                    r_d.state = smie_pkg::SMIE_RUN; // RL8
                end
            end
        endcase

        // Entry counter
        if (take) begin
            r_d.cnt = smie_pkg::ENTRY_CYCLES;
        end else if (is_entry) begin
            if (entry_last) begin
                r_d.cnt = smie_pkg::CNT_ZERO;
            end else begin
                r_d.cnt = cnt_dec;
            end
        end

        // Mode flag
        if (is_entry && entry_last) begin
            r_d.in_mgmt = 1'b1;
        end else if (resume_hit) begin
            r_d.in_mgmt = 1'b0;
        end

        // Indicator
        if (take) begin
            r_d.act_n = 1'b0; // RL9
        end else if (resume_hit) begin
            r_d.act_n = 1'b1; // RL10
        end else if (is_entry || is_mgmt) begin
            r_d.act_n = 1'b0; // RL10
        end
        // Inactive while the bus belongs to another master
        if (hold_ack) begin
            r_d.act_n = 1'b1; // RL11
        end

        // One-cycle start pulse, other-source take (high while other_ok holds) and the lock pin
        r_d.start = take;
        r_d.other_take = other_ok; // RL2
        r_d.lock_n = !locked_seq; // RL13
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_q <= '{state: smie_pkg::SMIE_RUN,
                     cnt: smie_pkg::CNT_ZERO,
                     act_n: 1'b1, // RL11
                     lock_n: 1'b1,
                     start: 1'b0,
                     other_take: 1'b0,
                     in_mgmt: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign mgmt_mode_active_n = r_q.act_n;
    assign lock_n = r_q.lock_n;
    assign mgmt_entry_start = r_q.start;
    assign other_irq_take = r_q.other_take;
    assign system_mgmt_state = r_q.in_mgmt;

endmodule

`default_nettype wire

// file: testbench/smie_entry_props.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Entry and indicator checks
// ------------------------------------------------------------
module smie_entry_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic mgmt_irq_req_n,
    input wire logic instr_boundary,
    input wire logic string_iter_boundary,
    input wire logic locked_seq,
    input wire logic hold_ack,
    input wire logic resume_from_mgmt_instr,
    input wire logic other_irq_req,
    input wire logic mgmt_mode_active_n,
    input wire logic lock_n,
    input wire logic mgmt_entry_start,
    input wire logic other_irq_take,
    input wire logic system_mgmt_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_entry;
        mgmt_entry_start ##4 system_mgmt_state;
    endsequence
    chk_entry_length: assert property (mgmt_entry_start |-> s_entry)
        else $error("entry length wrong");
    chk_start_active: assert property (
        mgmt_entry_start && !$past(hold_ack) |-> !mgmt_mode_active_n)
        else $error("no indicator");
    chk_mode_held: assert property (
        system_mgmt_state && !$past(hold_ack) |-> !mgmt_mode_active_n)
        else $error("indicator lost");
    chk_hold_high: assert property (
        $past(hold_ack) && hold_ack |-> mgmt_mode_active_n)
        else $error("low in hold");
    chk_no_nest: assert property (
        system_mgmt_state |-> !mgmt_entry_start)
        else $error("nested entry");
    chk_lock_defer: assert property (
        mgmt_entry_start |-> !$past(locked_seq))
        else $error("entry in lock");
    chk_lock_out: assert property (
        !$past(rst) |-> lock_n == !$past(locked_seq))
        else $error("lock out");
    chk_resume_exit: assert property (
        system_mgmt_state && resume_from_mgmt_instr
        |=> !system_mgmt_state && mgmt_mode_active_n)
        else $error("no exit");
    chk_single_pulse: assert property (
        mgmt_entry_start |=> !mgmt_entry_start)
        else $error("long start");
    chk_irq_rank: assert property (
        other_irq_take |-> !mgmt_entry_start)
        else $error("rank");
endmodule

bind smie_entry smie_entry_props u_smie_entry_props (
    .clk, .rst, .mgmt_irq_req_n, .instr_boundary, .string_iter_boundary,
    .locked_seq, .hold_ack, .resume_from_mgmt_instr, .other_irq_req,
    .mgmt_mode_active_n, .lock_n, .mgmt_entry_start, .other_irq_take,
    .system_mgmt_state
);
`default_nettype wire

// file: testbench/smie_pm_model.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Power-management controller
// ------------------------------------------------------------
// Only short low pulses: a held level would hide lost edges
module smie_pm_model (
    input wire logic clk,
    input wire logic fire,
    output logic req_n
);
    logic [1:0] cnt_q = 2'h0;
    always_ff @(posedge clk) begin
        if (fire) cnt_q <= 2'h2;
        else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
    end
    assign req_n = (cnt_q == 2'h0);
endmodule
`default_nettype wire

// file: testbench/smie_entry_tb.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, s) compares++; if ((s) !== (e)) begin \
    $display("[ERR] %s exp %h got %h", n, e, s); miscompares++; end

module smie_entry_tb;
    logic clk = 1'b0, rst = 1'b1, fire = 1'b0, instr_boundary = 1'b0;
    logic string_iter_boundary = 1'b0, locked_seq = 1'b0, hold_ack = 1'b0;
    logic resume_from_mgmt_instr = 1'b0, other_irq_req = 1'b0;
    logic mgmt_irq_req_n, mgmt_mode_active_n, lock_n, mgmt_entry_start;
    logic other_irq_take, system_mgmt_state;
    logic [7:0] nstart = 8'h0, ntake = 8'h0;
    int miscompares = 0, compares = 0, cycles = 0;

    smie_entry u_smie_entry (.clk, .rst, .mgmt_irq_req_n, .instr_boundary,
        .string_iter_boundary, .locked_seq, .hold_ack,
        .resume_from_mgmt_instr, .other_irq_req, .mgmt_mode_active_n,
        .lock_n, .mgmt_entry_start, .other_irq_take, .system_mgmt_state);
    smie_pm_model u_smie_pm_model (.clk, .fire, .req_n(mgmt_irq_req_n));

    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        nstart <= nstart + 8'(mgmt_entry_start);
        ntake <= ntake + 8'(other_irq_take);
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            test_done;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse_req;
        fire <= 1'b1;
        cyc(1);
        fire <= 1'b0;
    endtask
    task automatic resume;
        repeat (8) if (!system_mgmt_state) cyc(1);
        resume_from_mgmt_instr <= 1'b1;
        cyc(1);
        resume_from_mgmt_instr <= 1'b0;
        cyc(1);
        `CHK("idle", 1'b1, mgmt_mode_active_n)
    endtask
    task automatic wait_start(input logic [7:0] want);
        repeat (12) if (nstart != want) cyc(1);
        `CHK("entries", want, nstart)
    endtask

    task automatic t_locked_twice;
        locked_seq <= 1'b1;
        instr_boundary <= 1'b1;
        pulse_req;
        cyc(10);
        `CHK("lock_n", 1'b0, lock_n)
        `CHK("defer", 8'h0, nstart)
        locked_seq <= 1'b0;
        wait_start(8'h1);
        `CHK("active", 1'b0, mgmt_mode_active_n)
        pulse_req;
        cyc(10);
        `CHK("nested", 8'h1, nstart)
        `CHK("in mode", 1'b1, system_mgmt_state)
        hold_ack <= 1'b1;
        cyc(3);
        `CHK("hold", 1'b1, mgmt_mode_active_n)
        hold_ack <= 1'b0;
        cyc(2);
        resume;
        wait_start(8'h2);
        `CHK("late", 1'b0, mgmt_mode_active_n)
        resume;
        cyc(10);
        `CHK("once", 8'h2, nstart)
    endtask

    task automatic t_rank_string;
        instr_boundary <= 1'b0;
        other_irq_req <= 1'b1;
        pulse_req;
        cyc(8);
        `CHK("held", 8'h2, nstart)
        instr_boundary <= 1'b1;
        wait_start(8'h3);
        `CHK("rank", 8'h0, ntake)
        resume;
        cyc(2);
        `CHK("other", 1'b1, ntake != 8'h0)
        instr_boundary <= 1'b0;
        other_irq_req <= 1'b0;
        string_iter_boundary <= 1'b1;
        pulse_req;
        wait_start(8'h4);
        string_iter_boundary <= 1'b0;
        resume;
    endtask

    task automatic test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        cyc(3);
        rst <= 1'b0;
        cyc(5);
        `CHK("reset", 1'b1, mgmt_mode_active_n)
        t_locked_twice;
        t_rank_string;
        test_done;
    end
endmodule
`default_nettype wire
